// ===== core/ahc_regs_defs.vh
/*
 * Register offsets, reset values and widths of the ADC high-pass
 * coefficient bank on page 1 of the codec control map.
 * Assumes the includer wants plain `define constants, no logic.
 */
`ifndef AHC_REGS_DEFS_VH
`define AHC_REGS_DEFS_VH

`define AHC_ADDR_W 7
`define AHC_DATA_W 8
`define AHC_COEF_W 16

// Register offsets
`define AHC_OFF_LEFT_DEN1_LOW 7'h46
`define AHC_OFF_RIGHT_NUM0_HIGH 7'h47
`define AHC_OFF_RIGHT_NUM0_LOW 7'h48
`define AHC_OFF_RIGHT_NUM1_HIGH 7'h49
`define AHC_OFF_RIGHT_NUM1_LOW 7'h4A
`define AHC_OFF_RIGHT_DEN1_HIGH 7'h4B
`define AHC_OFF_RIGHT_DEN1_LOW 7'h4C
`define AHC_OFF_RSVD_FIRST 7'h4D
`define AHC_OFF_RSVD_LAST 7'h7F

// Reset values
`define AHC_RST_LEFT_DEN1_LOW 8'h7E
`define AHC_RST_RIGHT_NUM0_HIGH 8'h39
`define AHC_RST_RIGHT_NUM0_LOW 8'h55
`define AHC_RST_RIGHT_NUM1_HIGH 8'hF3
`define AHC_RST_RIGHT_NUM1_LOW 8'h2D
`define AHC_RST_RIGHT_DEN1_HIGH 8'h53
`define AHC_RST_RIGHT_DEN1_LOW 8'h7E
`define AHC_RST_RSVD 8'h00
`define AHC_RST_RD_DATA 8'h00

`endif

// ===== core/ahc_regs.v
/*
 * ADC high-pass coefficient register bank: left denominator-one low
 * byte and the full right-channel coefficient set, plus the reserved
 * upper page locations that read as zero.
 * Assumes the codec control-bus decoder (serial or two-wire) hands over
 * one byte access per cycle on clk, already synchronised to clk, with
 * the page-1 select already resolved. The left denominator-one high byte
 * lives in the neighbouring bank and arrives as an input.
 */
`timescale 1ns/1ps
`include "ahc_regs_defs.vh"

// Functional notes
// - Each coefficient is high byte then low byte, one signed 16-bit word.
// - Left denominator-one low byte resets to 0x7E and is read/write.
// - Right numerator-zero resets to 0x39/0x55, both bytes read/write.
// - Right numerator-one resets to 0xF3/0x2D, both bytes read/write.
// - Right denominator-one resets to 0x53/0x7E, both bytes read/write.
// - Locations 77 to 127 read zero; host must never write them.
module ahc_regs (
    input wire clk,
    input wire rst,
    input wire regWrEn,
    input wire regRdEn,
    input wire [`AHC_ADDR_W-1:0] regAddr,
    input wire [`AHC_DATA_W-1:0] regWrData,
    output reg [`AHC_DATA_W-1:0] regRdData,
    output reg regRdValid,
    input wire [`AHC_DATA_W-1:0] leftDen1High,
    output wire [`AHC_COEF_W-1:0] leftDenominatorOneCoefficient,
    output wire [`AHC_COEF_W-1:0] rightNumeratorZeroCoefficient,
    output wire [`AHC_COEF_W-1:0] rightNumeratorOneCoefficient,
    output wire [`AHC_COEF_W-1:0] rightDenominatorOneCoefficient
);

    // Bank geometry; entry 0 sits at the lowest held offset
    localparam NUM_ENTRIES = 7;
    localparam IDX_LEFT_DEN1_LOW = 0;
    localparam IDX_RIGHT_NUM0_HIGH = 1;
    localparam IDX_RIGHT_NUM0_LOW = 2;
    localparam IDX_RIGHT_NUM1_HIGH = 3;
    localparam IDX_RIGHT_NUM1_LOW = 4;
    localparam IDX_RIGHT_DEN1_HIGH = 5;
    localparam IDX_RIGHT_DEN1_LOW = 6;
    localparam TABLE_OFF_W = NUM_ENTRIES * `AHC_ADDR_W;
    localparam TABLE_DATA_W = NUM_ENTRIES * `AHC_DATA_W;

    // Offset of each entry; the last item of the list is entry 0
    localparam [TABLE_OFF_W-1:0] OFF_TABLE = {
        `AHC_OFF_RIGHT_DEN1_LOW,
        `AHC_OFF_RIGHT_DEN1_HIGH,
        `AHC_OFF_RIGHT_NUM1_LOW,
        `AHC_OFF_RIGHT_NUM1_HIGH,
        `AHC_OFF_RIGHT_NUM0_LOW,
        `AHC_OFF_RIGHT_NUM0_HIGH,
        `AHC_OFF_LEFT_DEN1_LOW
    };

    // Reset byte of each entry, in the same order as the offsets
    localparam [TABLE_DATA_W-1:0] RST_TABLE = {
        `AHC_RST_RIGHT_DEN1_LOW,
        `AHC_RST_RIGHT_DEN1_HIGH,
        `AHC_RST_RIGHT_NUM1_LOW,
        `AHC_RST_RIGHT_NUM1_HIGH,
        `AHC_RST_RIGHT_NUM0_LOW,
        `AHC_RST_RIGHT_NUM0_HIGH,
        `AHC_RST_LEFT_DEN1_LOW
    };

    // Decode, storage taps and read path
    wire [NUM_ENTRIES-1:0] entryHit;
    wire [NUM_ENTRIES-1:0] entryWrEn;
    wire [TABLE_DATA_W-1:0] entryBytes;
    wire [TABLE_DATA_W-1:0] entryRdTerm;
    wire rsvdHit;
    reg [`AHC_DATA_W-1:0] rdData_nxt;
    integer rdIdx;

    // Named views of the stored bytes for coefficient assembly
    wire [`AHC_DATA_W-1:0] leftDen1Low;
    wire [`AHC_DATA_W-1:0] rightNum0High;
    wire [`AHC_DATA_W-1:0] rightNum0Low;
    wire [`AHC_DATA_W-1:0] rightNum1High;
    wire [`AHC_DATA_W-1:0] rightNum1Low;
    wire [`AHC_DATA_W-1:0] rightDen1High;
    wire [`AHC_DATA_W-1:0] rightDen1Low;

    // Reserved window runs from its first offset to the page end
    assign rsvdHit = (regAddr >= `AHC_OFF_RSVD_FIRST);

    // One storage byte per held offset; a write lands on its strobe edge
    genvar gi;
    generate
        for (gi = 0; gi < NUM_ENTRIES; gi = gi + 1) begin : g_entry
            localparam [`AHC_ADDR_W-1:0] ENTRY_OFF =
                OFF_TABLE[gi*`AHC_ADDR_W +: `AHC_ADDR_W];
            localparam [`AHC_DATA_W-1:0] ENTRY_RST =
                RST_TABLE[gi*`AHC_DATA_W +: `AHC_DATA_W];
            reg [`AHC_DATA_W-1:0] entryByte_r;

            // Exact match only, so reserved writes touch nothing
            assign entryHit[gi] = (regAddr == ENTRY_OFF);
            assign entryWrEn[gi] = regWrEn & entryHit[gi];

            // No shadowing: a half-written word is seen by the filter
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    entryByte_r <= ENTRY_RST;
                end else if (entryWrEn[gi]) begin
                    entryByte_r <= regWrData;
                end
            end

            // Flat taps for the read mux and coefficient assembly
            assign entryBytes[gi*`AHC_DATA_W +: `AHC_DATA_W] = entryByte_r;
            assign entryRdTerm[gi*`AHC_DATA_W +: `AHC_DATA_W] =
                entryHit[gi] ? entryByte_r : `AHC_RST_RSVD;
        end
    endgenerate

    // Byte views; slicing by index keeps the tables the single source
    assign leftDen1Low =
        entryBytes[IDX_LEFT_DEN1_LOW*`AHC_DATA_W +: `AHC_DATA_W];
    assign rightNum0High =
        entryBytes[IDX_RIGHT_NUM0_HIGH*`AHC_DATA_W +: `AHC_DATA_W];
    assign rightNum0Low =
        entryBytes[IDX_RIGHT_NUM0_LOW*`AHC_DATA_W +: `AHC_DATA_W];
    assign rightNum1High =
        entryBytes[IDX_RIGHT_NUM1_HIGH*`AHC_DATA_W +: `AHC_DATA_W];
    assign rightNum1Low =
        entryBytes[IDX_RIGHT_NUM1_LOW*`AHC_DATA_W +: `AHC_DATA_W];
    assign rightDen1High =
        entryBytes[IDX_RIGHT_DEN1_HIGH*`AHC_DATA_W +: `AHC_DATA_W];
    assign rightDen1Low =
        entryBytes[IDX_RIGHT_DEN1_LOW*`AHC_DATA_W +: `AHC_DATA_W];

    // OR of the per-entry terms; at most one entry matches an offset
    always @* begin
        rdData_nxt = `AHC_RST_RSVD;
        for (rdIdx = 0; rdIdx < NUM_ENTRIES; rdIdx = rdIdx + 1) begin
            rdData_nxt = rdData_nxt |
                entryRdTerm[rdIdx*`AHC_DATA_W +: `AHC_DATA_W];
        end
        // Reserved page forced to zero even if an entry is added there
        if (rsvdHit) begin
            rdData_nxt = `AHC_RST_RSVD;
        end
    end

    // Registered read answer, one cycle after the strobe
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdData <= `AHC_RST_RD_DATA;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            if (regRdEn) begin
                regRdData <= rdData_nxt;
            end
        end
    end

    // High byte on top keeps the sign bit where the filter expects it
    assign leftDenominatorOneCoefficient =
        {leftDen1High, leftDen1Low};
    assign rightNumeratorZeroCoefficient =
        {rightNum0High, rightNum0Low};
    assign rightNumeratorOneCoefficient =
        {rightNum1High, rightNum1Low};
    assign rightDenominatorOneCoefficient =
        {rightDen1High, rightDen1Low};

endmodule

// ===== verif/ahc_regs_asserts.sv
/* Port checker for ahc_regs; assumes one clock, async reset. */
`timescale 1ns/1ps
module ahc_regs_asserts (input logic clk, rst, regWrEn, regRdEn, regRdValid,
    input logic [6:0] regAddr, input logic [7:0] regWrData, regRdData,
    input logic [7:0] leftDen1High, input logic [15:0]
    leftDenominatorOneCoefficient, rightNumeratorZeroCoefficient,
    rightNumeratorOneCoefficient, rightDenominatorOneCoefficient);
    // Right set as six bytes; no shadowing, so bytes move alone
    wire [47:0] rb = {rightNumeratorZeroCoefficient,
        rightNumeratorOneCoefficient, rightDenominatorOneCoefficient};
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_left; regWrEn && regAddr == 7'h46 |=>
        leftDenominatorOneCoefficient == {leftDen1High, $past(regWrData)};
    endproperty
    a_left: assert property (p_left) else $error("left");
    property p_right; regWrEn && regAddr inside {[7'h47:7'h4C]} |=>
        rb[(7'h4C - $past(regAddr)) * 8 +: 8] == $past(regWrData);
    endproperty
    a_right: assert property (p_right) else $error("right");
    property p_rsvd; regRdEn && regAddr > 7'h4C |=> !regRdData; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved");
    property p_indep; regWrEn && regAddr == 7'h46 |=> $stable(rb); endproperty
    a_indep: assert property (p_indep) else $error("cross");
    property p_rdleft; regRdEn && regAddr == 7'h46 |=> regRdValid &&
        regRdData == $past(leftDenominatorOneCoefficient[7:0]);
    endproperty
    a_rdleft: assert property (p_rdleft) else $error("rdleft");
    property p_rdright; regRdEn && regAddr inside {[7'h47:7'h4C]} |=>
        regRdValid && regRdData == $past(rb[(7'h4C - regAddr) * 8 +: 8]);
    endproperty
    a_rdright: assert property (p_rdright) else $error("rdright");
    property p_reset; $fell(rst) |-> rb == 48'h3955F32D537E &&
        leftDenominatorOneCoefficient[7:0] == 8'h7E;
    endproperty
    a_reset: assert property (p_reset) else $error("reset");
endmodule
bind ahc_regs ahc_regs_asserts u_chk (.*);

// ===== verif/ahc_regs_tb.sv
/* Bench for ahc_regs; assumes the checker is bound alongside. */
`timescale 1ns/1ps
module ahc_regs_tb;
    logic clk = 0, rst = 1, regWrEn = 0, regRdEn = 0, regRdValid;
    logic [6:0] regAddr = 0;
    logic [7:0] regWrData = 0, leftDen1High = 8'hA5, regRdData;
    logic [55:0] rv = 56'h7E3955F32D537E;
    wire [15:0] leftDenominatorOneCoefficient, rightNumeratorZeroCoefficient;
    wire [15:0] rightNumeratorOneCoefficient, rightDenominatorOneCoefficient;
    int err_total = 0, checks_done = 0, cyc = 0;
    ahc_regs DUT (.*);
    // Clock, and a ceiling far past the roughly 70 cycles used
    initial forever #25 clk = ~clk;
    always @(posedge clk) if (++cyc > 2000) begin err_total++; close_out; end
    task acc(input w, input [6:0] a, input [7:0] d);
        @(negedge clk);
        {regWrEn, regRdEn, regAddr, regWrData} = {w, !w, a, d};
        @(negedge clk);
        {regWrEn, regRdEn} = 2'b00;
        checks_done += !w;
        if (!w && {regRdValid, regRdData} !== {1'b1, d}) begin
            err_total++;
            $display("wrong value %0t read %h", $time, regRdData);
        end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %0t got %h want %h", $time, got, exp);
        end
    endtask
    task t_reset;
        for (int i = 0; i < 7; i++)
            acc(0, 7'(70 + i), rv[55 - 8 * i -: 8]);
    endtask
    task t_rw;
        for (int i = 0; i < 7; i++)
            acc(1, 7'(70 + i), 8'(128 + 9 * i));
        for (int i = 0; i < 7; i++)
            acc(0, 7'(70 + i), 8'(128 + 9 * i));
    endtask
    task t_rsvd;
        acc(0, 7'h4D, 8'h00);
        acc(0, 7'h7F, 8'h00);
    endtask
    // Words built from the bytes of t_rw; left high byte from the pin
    task t_coef;
        @(negedge clk);
        chk(rightNumeratorZeroCoefficient, 16'h8992);
        chk(rightNumeratorOneCoefficient, 16'h9BA4);
        chk(rightDenominatorOneCoefficient, 16'hADB6);
        chk(leftDenominatorOneCoefficient, 16'hA580);
        leftDen1High = 8'h5A;
        @(negedge clk);
        chk(leftDenominatorOneCoefficient, 16'h5A80);
        chk(rightNumeratorZeroCoefficient, 16'h8992);
    endtask
    // Second reset mid-run must bring back every default
    task t_rerst;
        @(negedge clk);
        rst = 1;
        @(negedge clk);
        @(negedge clk);
        rst = 0;
        chk(leftDenominatorOneCoefficient, 16'h5A7E);
        chk(rightNumeratorZeroCoefficient, 16'h3955);
        chk(rightNumeratorOneCoefficient, 16'hF32D);
        chk(rightDenominatorOneCoefficient, 16'h537E);
        t_reset;
    endtask
    task close_out;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Four reset cycles, then the scenarios
    initial begin
        #200 rst = 0;
        t_reset;
        t_rw;
        t_coef;
        t_rsvd;
        t_rerst;
        close_out;
    end
endmodule
